/* File: src/i2cbr_map.vh */
// constants for the two-wire slave to usb data bridge
`ifndef I2CBR_MAP_VH
`define I2CBR_MAP_VH

`define I2CBR_CLK_MHZ      200
`define I2CBR_LAT_US       16
`define I2CBR_LAT_CYCLES   (`I2CBR_LAT_US * `I2CBR_CLK_MHZ)
`define I2CBR_RX_DEPTH     64
`define I2CBR_TX_DEPTH     64
`define I2CBR_GCALL_ADDR   8'h00
`define I2CBR_CMD_AVAIL    8'h0C
`define I2CBR_COUNT_SAT    8'hFF
`define I2CBR_IDLE_BYTE    8'hFF
`define I2CBR_BITS_BYTE    4'h8
`define I2CBR_RW_BIT       0

`endif

/* File: src/i2cbr_sync.v */
// two flip-flop synchroniser for a single pin
`timescale 1ns/1ps
module i2cbr_sync (
    input  wire clk,
    input  wire rst,
    input  wire pinIn,
    output reg  pinOut_q
);
    reg stage1_q;

    // pins idle high, so reset to the released level
    always @(posedge clk) begin
        if (rst) begin
            stage1_q <= 1'b1;
            pinOut_q <= 1'b1;
        end else begin
            stage1_q <= pinIn;
            pinOut_q <= stage1_q;
        end
    end
endmodule // i2cbr_sync

/* File: src/i2cbr_fifo.v */
// byte buffer with registered count and flags
`timescale 1ns/1ps
module i2cbr_fifo #(
    parameter W     = 8,
    parameter DEPTH = 64,
    parameter AW    = 6
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          wrEn,
    input  wire [W-1:0]  wrData,
    input  wire          rdEn,
    output wire [W-1:0]  rdData,
    output reg  [AW:0]   count_q,
    output reg           notFull_q,
    output reg           notEmpty_q
);
    reg  [W-1:0]  mem [0:DEPTH-1];
    reg  [AW-1:0] wrPtr_q;
    reg  [AW-1:0] rdPtr_q;
    wire          doWr = wrEn & notFull_q;
    wire          doRd = rdEn & notEmpty_q;
    reg  [AW:0]   count_d;

    assign rdData = mem[rdPtr_q];

    // next occupancy; flags follow it so they are flops, not decodes
    always @* begin
        count_d = count_q;
        if (doWr & ~doRd)
            count_d = count_q + 1'b1;
        else if (doRd & ~doWr)
            count_d = count_q - 1'b1;
    end

    always @(posedge clk) begin
        if (doWr)
            mem[wrPtr_q] <= wrData;
    end

    // pointers wrap at DEPTH so any depth works, not only powers of two
    always @(posedge clk) begin
        if (rst) begin
            wrPtr_q    <= {AW{1'b0}};
            rdPtr_q    <= {AW{1'b0}};
            count_q    <= {(AW+1){1'b0}};
            notFull_q  <= 1'b1;
            notEmpty_q <= 1'b0;
        end else begin
            if (doWr)
                wrPtr_q <= (wrPtr_q == DEPTH-1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
            if (doRd)
                rdPtr_q <= (rdPtr_q == DEPTH-1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
            count_q    <= count_d;
            notFull_q  <= (count_d != DEPTH);
            notEmpty_q <= (count_d != {(AW+1){1'b0}});
        end
    end
endmodule // i2cbr_fifo

/* File: src/i2cbr_bridge.v */
// two-wire bus slave bridging master writes upstream and host data to master reads
`timescale 1ns/1ps
`include "i2cbr_map.vh"
module i2cbr_bridge #(
    parameter RX_DEPTH   = `I2CBR_RX_DEPTH,
    parameter RX_AW      = 6,
    parameter TX_DEPTH   = `I2CBR_TX_DEPTH,
    parameter TX_AW      = 6,
    parameter LAT_CYCLES = `I2CBR_LAT_CYCLES
) (
    input  wire             core_clk,
    input  wire             sys_rst,
    input  wire             sclIn,
    input  wire             sdaIn,
    output reg              sdaOut_q,
    output reg              sdaOe_q,
    input  wire [6:0]       cfgSlaveAddr,
    input  wire             cfgChargeEnable,
    input  wire             cfgChargeActiveLow,
    input  wire             usbSuspended,
    input  wire             dcpDetected,
    output reg              chargeDetect_q,
    input  wire             txWrValid,
    input  wire [7:0]       txWrData,
    output wire             txWrReady,
    output reg              upValid_q,
    output reg  [7:0]       upData_q,
    input  wire             upReady,
    output wire [RX_AW:0]   rxLevel,
    output wire [TX_AW:0]   txLevel
);
    // bus states
    localparam ST_IDLE  = 4'd0;
    localparam ST_ADDR  = 4'd1;
    localparam ST_AACK  = 4'd2;
    localparam ST_WDATA = 4'd3;
    localparam ST_WACK  = 4'd4;
    localparam ST_RDATA = 4'd5;
    localparam ST_RACK  = 4'd6;
    localparam ST_GCMD  = 4'd7;
    localparam ST_GACK  = 4'd8;
    localparam ST_SKIP  = 4'd9;

    wire        sclS;
    wire        sdaS;
    reg         sclPrev_q;
    reg         sdaPrev_q;
    reg  [3:0]  state_q;
    reg  [3:0]  bitCnt_q;
    reg  [7:0]  shiftIn_q;
    reg  [7:0]  shiftOut_q;
    reg         isRead_q;
    reg         isGcall_q;
    reg         availPend_q;
    reg         rxPush;
    reg         txPop;
    reg         rxPop;
    reg         flush_q;
    reg  [31:0] latCnt_q;
    wire [7:0]  rxHead;
    wire [7:0]  txHead;
    wire        rxNotFull;
    wire        rxNotEmpty;
    wire        txNotEmpty;
    wire [RX_AW:0] rxCount;
    wire [TX_AW:0] txCount;

    // bus pins cross into core_clk first; the slave never drives the clock
    i2cbr_sync u_sclSync (
        .clk     (core_clk),
        .rst     (sys_rst),
        .pinIn   (sclIn),
        .pinOut_q(sclS)
    );
    i2cbr_sync u_sdaSync (
        .clk     (core_clk),
        .rst     (sys_rst),
        .pinIn   (sdaIn),
        .pinOut_q(sdaS)
    );

    // master write data waiting to go upstream
    i2cbr_fifo #(.W(8), .DEPTH(RX_DEPTH), .AW(RX_AW)) u_rxBuf (
        .clk       (core_clk),
        .rst       (sys_rst),
        .wrEn      (rxPush),
        .wrData    (shiftIn_q),
        .rdEn      (rxPop),
        .rdData    (rxHead),
        .count_q   (rxCount),
        .notFull_q (rxNotFull),
        .notEmpty_q(rxNotEmpty)
    );

    // host data waiting for master reads, kept in arrival order
    i2cbr_fifo #(.W(8), .DEPTH(TX_DEPTH), .AW(TX_AW)) u_txBuf (
        .clk       (core_clk),
        .rst       (sys_rst),
        .wrEn      (txWrValid),
        .wrData    (txWrData),
        .rdEn      (txPop),
        .rdData    (txHead),
        .count_q   (txCount),
        .notFull_q (txWrReady),
        .notEmpty_q(txNotEmpty)
    );

    assign rxLevel = rxCount;
    assign txLevel = txCount;

    // count of host bytes clipped to one byte for the status command
    // widened first so any buffer depth, small or large, compares cleanly
    function [7:0] satCount;
        input [TX_AW:0] cnt;
        reg   [31:0]    wide;
        begin
            wide = {{(31-TX_AW){1'b0}}, cnt};
            if (wide >= {24'h00_0000, `I2CBR_COUNT_SAT})
                satCount = `I2CBR_COUNT_SAT;
            else
                satCount = wide[7:0];
        end
    endfunction

    wire [7:0] availCnt = satCount(txCount);

    // edges found on synchronised copies; at 200 MHz a 3.4 Mbit/s bit
    // still spans dozens of cycles, so no edge is missed
    wire sclRise = sclS & ~sclPrev_q;
    wire sclFall = ~sclS & sclPrev_q;
    wire startC  = sclS & sclPrev_q & ~sdaS & sdaPrev_q;
    wire stopC   = sclS & sclPrev_q & sdaS & ~sdaPrev_q;
    wire byteIn  = (bitCnt_q == `I2CBR_BITS_BYTE);

    // address match uses the stored address only; no bus baud setting exists
    wire addrHit = (shiftIn_q[7:1] == cfgSlaveAddr);
    wire rdReq   = shiftIn_q[`I2CBR_RW_BIT];
    wire gcHit   = (shiftIn_q == `I2CBR_GCALL_ADDR);
    wire rdOk    = txNotEmpty | availPend_q;

    // pushes and pops happen on the single cycle of the scl edge
    always @* begin
        rxPush = 1'b0;
        txPop  = 1'b0;
        if (!startC && !stopC && sclFall) begin
            if (state_q == ST_WDATA && byteIn && rxNotFull)
                rxPush = 1'b1;
            if (state_q == ST_AACK && isRead_q && !isGcall_q && !availPend_q)
                txPop = 1'b1;
            if (state_q == ST_RACK && !sdaOe_q && isRead_q && !sdaPrev_q)
                txPop = 1'b1;
        end
    end

    // bus state machine
    always @(posedge core_clk) begin
        if (sys_rst) begin
            sclPrev_q   <= 1'b1;
            sdaPrev_q   <= 1'b1;
            state_q     <= ST_IDLE;
            bitCnt_q    <= 4'h0;
            shiftIn_q   <= 8'h00;
            shiftOut_q  <= 8'h00;
            isRead_q    <= 1'b0;
            isGcall_q   <= 1'b0;
            availPend_q <= 1'b0;
            sdaOut_q    <= 1'b0;
            sdaOe_q     <= 1'b0;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
            sdaOut_q  <= 1'b0;          // open drain: only ever pulls low
            if (startC) begin
                // a start in mid message is a repeated start
                state_q  <= ST_ADDR;
                bitCnt_q <= 4'h0;
                sdaOe_q  <= 1'b0;
            end else if (stopC) begin
                state_q <= ST_IDLE;
                sdaOe_q <= 1'b0;
            end else begin
                // receiving states take one bit per rising clock, msb first
                if (sclRise && (state_q == ST_ADDR || state_q == ST_WDATA ||
                                state_q == ST_GCMD)) begin
                    shiftIn_q <= {shiftIn_q[6:0], sdaS};
                    bitCnt_q  <= bitCnt_q + 4'h1;
                end
                if (sclRise && state_q == ST_RDATA)
                    bitCnt_q <= bitCnt_q + 4'h1;
                // master answer to our byte, held in isRead_q for the fall
                if (sclRise && state_q == ST_RACK)
                    isRead_q <= ~sdaS;
                if (sclFall) begin
                    case (state_q)
                        ST_ADDR: if (byteIn) begin
                            if (gcHit) begin
                                isGcall_q <= 1'b1;
                                isRead_q  <= 1'b0;
                                sdaOe_q   <= 1'b1;
                                state_q   <= ST_AACK;
                            end else if (addrHit && (!rdReq || rdOk)) begin
                                isGcall_q <= 1'b0;
                                isRead_q  <= rdReq;
                                sdaOe_q   <= 1'b1;
                                state_q   <= ST_AACK;
                            end else
                                state_q <= ST_SKIP;
                        end
                        ST_AACK: begin
                            bitCnt_q <= 4'h0;
                            if (isGcall_q) begin
                                sdaOe_q <= 1'b0;
                                state_q <= ST_GCMD;
                            end else if (isRead_q) begin
                                // status byte first if it was asked for
                                if (availPend_q) begin
                                    shiftOut_q  <= availCnt;
                                    sdaOe_q     <= ~availCnt[7];
                                    availPend_q <= 1'b0;
                                end else begin
                                    shiftOut_q <= txHead;
                                    sdaOe_q    <= ~txHead[7];
                                end
                                state_q <= ST_RDATA;
                            end else begin
                                sdaOe_q <= 1'b0;
                                state_q <= ST_WDATA;
                            end
                        end
                        ST_WDATA: if (byteIn) begin
                            // a full buffer refuses the byte with a not-acknowledge
                            sdaOe_q <= rxNotFull;
                            state_q <= rxNotFull ? ST_WACK : ST_SKIP;
                        end
                        ST_WACK: begin
                            sdaOe_q  <= 1'b0;
                            bitCnt_q <= 4'h0;
                            state_q  <= ST_WDATA;
                        end
                        ST_GCMD: if (byteIn) begin
                            if (shiftIn_q == `I2CBR_CMD_AVAIL) begin
                                sdaOe_q <= 1'b1;
                                state_q <= ST_GACK;
                            end else
                                state_q <= ST_SKIP;
                        end
                        ST_GACK: begin
                            // the count is returned on the next read to us
                            sdaOe_q     <= 1'b0;
                            availPend_q <= 1'b1;
                            state_q     <= ST_SKIP;
                        end
                        ST_RDATA: begin
                            if (byteIn) begin
                                sdaOe_q <= 1'b0;
                                state_q <= ST_RACK;
                            end else begin
                                shiftOut_q <= {shiftOut_q[6:0], 1'b0};
                                sdaOe_q    <= ~shiftOut_q[6];
                            end
                        end
                        ST_RACK: begin
                            bitCnt_q <= 4'h0;
                            if (isRead_q) begin
                                // an empty buffer gives idle-high filler bytes
                                if (txNotEmpty) begin
                                    shiftOut_q <= txHead;
                                    sdaOe_q    <= ~txHead[7];
                                end else begin
                                    shiftOut_q <= `I2CBR_IDLE_BYTE;
                                    sdaOe_q    <= 1'b0;
                                end
                                state_q <= ST_RDATA;
                            end else begin
                                sdaOe_q <= 1'b0;
                                state_q <= ST_SKIP;
                            end
                        end
                        ST_SKIP: sdaOe_q <= 1'b0;
                        ST_IDLE: sdaOe_q <= 1'b0;
                        default: begin
                            sdaOe_q <= 1'b0;
                            state_q <= ST_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // latency timer runs while unsent data waits; full or timeout starts a flush
    always @(posedge core_clk) begin
        if (sys_rst) begin
            latCnt_q <= 32'h0000_0000;
            flush_q  <= 1'b0;
        end else begin
            if (!rxNotFull || (latCnt_q >= LAT_CYCLES - 1)) begin
                flush_q  <= 1'b1;
                latCnt_q <= 32'h0000_0000;
            end else if (flush_q && !rxNotEmpty && !upValid_q) begin
                flush_q <= 1'b0;
            end
            if (flush_q || !rxNotEmpty)
                latCnt_q <= 32'h0000_0000;
            else if (rxNotFull && (latCnt_q < LAT_CYCLES - 1))
                latCnt_q <= latCnt_q + 32'h0000_0001;
        end
    end

    // upstream drain; a stalled upReady simply holds the byte
    always @* begin
        rxPop = flush_q & rxNotEmpty & (~upValid_q | upReady);
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            upValid_q <= 1'b0;
            upData_q  <= 8'h00;
        end else if (rxPop) begin
            upValid_q <= 1'b1;
            upData_q  <= rxHead;
        end else if (upReady) begin
            upValid_q <= 1'b0;
        end
    end

    // charger flag only while suspended; polarity from the io pin setting
    always @(posedge core_clk) begin
        if (sys_rst)
            chargeDetect_q <= 1'b0;
        else
            chargeDetect_q <= (cfgChargeEnable & usbSuspended & dcpDetected)
                              ^ cfgChargeActiveLow;
    end
endmodule // i2cbr_bridge

/* File: dv/i2cbr_chk.sv */
// concurrent checks on the ports of the two-wire slave bridge
`timescale 1ns/1ps
module i2cbr_chk #(
    parameter RX_DEPTH = 4,
    parameter RX_AW    = 2,
    parameter TX_DEPTH = 4,
    parameter TX_AW    = 2
) (
    input wire logic             core_clk,
    input wire logic             sys_rst,
    input wire logic             sclIn,
    input wire logic             sdaIn,
    input wire logic             sdaOut_q,
    input wire logic             sdaOe_q,
    input wire logic             cfgChargeEnable,
    input wire logic             cfgChargeActiveLow,
    input wire logic             usbSuspended,
    input wire logic             dcpDetected,
    input wire logic             chargeDetect_q,
    input wire logic             txWrValid,
    input wire logic             txWrReady,
    input wire logic             upValid_q,
    input wire logic [7:0]       upData_q,
    input wire logic             upReady,
    input wire logic [RX_AW:0]   rxLevel,
    input wire logic [TX_AW:0]   txLevel
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // open drain: only the enable may ever change the wire
    sda_out_zero_a: assert property (sdaOut_q == 1'b0)
        else $error("data output value not low");
    // slave starts pulling data low only in the low phase of the master clock
    oe_rise_low_a: assert property ($rose(sdaOe_q) |-> !sclIn && !$past(sclIn, 2))
        else $error("slave pulled data outside clock low phase");
    // after a stop the slave keeps off the wire
    stop_release_a: assert property (sclIn && $rose(sdaIn) |=> !sdaOe_q [*8])
        else $error("slave drove data after stop");
    // stalled upstream byte holds still
    up_hold_a: assert property (upValid_q && !upReady |=> upValid_q && $stable(upData_q))
        else $error("upstream byte dropped while stalled");
    up_source_a: assert property ($rose(upValid_q) |-> $past(rxLevel) != 0)
        else $error("upstream valid without buffered data");
    level_bound_a: assert property (rxLevel <= RX_DEPTH && txLevel <= TX_DEPTH)
        else $error("buffer level beyond depth");
    ready_level_a: assert property (txWrReady == (txLevel != TX_DEPTH))
        else $error("host ready disagrees with level");
    // only a taken host write can grow the transmit buffer
    tx_rise_host_a: assert property (txLevel > $past(txLevel) |-> $past(txWrValid && txWrReady))
        else $error("transmit level grew without host write");
    // bytes land in the receive buffer at a clock fall
    rx_push_low_a: assert property (rxLevel > $past(rxLevel) |-> !sclIn && !$past(sclIn))
        else $error("receive push outside clock low phase");
    charge_expr_a: assert property (!$past(sys_rst) |-> chargeDetect_q == $past(
        (cfgChargeEnable && usbSuspended && dcpDetected) ^ cfgChargeActiveLow))
        else $error("charger output wrong");
    charge_idle_a: assert property (!$past(sys_rst) && !$past(usbSuspended) |->
        chargeDetect_q == $past(cfgChargeActiveLow))
        else $error("charger output active while not suspended");

    // main scenarios reached
    cover property ($rose(upValid_q));
    cover property ($fell(txWrReady));
    cover property ($rose(chargeDetect_q));
endmodule // i2cbr_chk

/* File: dv/i2cbr_master.sv */
// bus master model that clocks the two-wire link and moves bytes
`timescale 1ns/1ps
module i2cbr_master (
    input  wire logic clk,
    output logic      scl,
    output logic      sdaLow,
    input  wire logic sda
);
    // idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // quarter of an 80 ns bit, changes land just after a core edge
    task automatic quarter();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // start or repeated start: data falls while the clock is high
    task automatic startBit();
        quarter();
        sdaLow = 1'b0;
        quarter();
        scl = 1'b1;
        quarter();
        sdaLow = 1'b1;
        quarter();
        scl = 1'b0;
    endtask
    // stop: data rises while the clock is high, clock then stands still
    task automatic stopBit();
        quarter();
        sdaLow = 1'b1;
        quarter();
        scl = 1'b1;
        quarter();
        sdaLow = 1'b0;
        quarter();
    endtask
    // one bit: data set mid low phase, sampled mid high phase
    task automatic bitSlot(input logic b, output logic v);
        quarter();
        sdaLow = ~b;
        quarter();
        scl = 1'b1;
        quarter();
        v = sda;
        quarter();
        scl = 1'b0;
    endtask
    // byte then acknowledge slot; slot 1 releases, 0 acknowledges a read
    task automatic xfer(input logic [7:0] d, input logic slot, output logic [7:0] r,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bitSlot(d[i], r[i]);
        end
        bitSlot(slot, ack);
    endtask
endmodule // i2cbr_master

/* File: dv/i2cbr_bridge_bench.sv */
// self-checking bench for the two-wire slave to usb data bridge
`timescale 1ns/1ps
module i2cbr_bridge_bench;
    localparam int LAT = 1000;
    localparam logic [7:0] PAT [4] = '{8'h81, 8'h42, 8'hA5, 8'h3C};
    logic       coreClk;
    logic       sysRst;
    logic       sclLine;
    logic       sdaLow;
    wire        sdaWire;
    logic       sdaOut_q;
    logic       sdaOe_q;
    logic [6:0] cfgSlaveAddr;
    logic       cfgChargeEnable;
    logic       cfgChargeActiveLow;
    logic       usbSuspended;
    logic       dcpDetected;
    logic       chargeDetect_q;
    logic       txWrValid;
    logic [7:0] txWrData;
    logic       txWrReady;
    logic       upValid_q;
    logic [7:0] upData_q;
    logic       upReady;
    logic [2:0] rxLevel;
    logic [2:0] txLevel;
    int         err_count;
    int         tests_run;
    int         cycles = 0;
    logic [7:0] expQ[$];

    // pull-up on the data wire, either party may pull it low
    assign sdaWire = ~(sdaLow | sdaOe_q);

    // small buffers so full is reached quickly; long latency so full wins first
    i2cbr_bridge #(.RX_DEPTH(4), .RX_AW(2), .TX_DEPTH(4), .TX_AW(2), .LAT_CYCLES(LAT))
    u_i2cbr_bridge (.core_clk(coreClk), .sys_rst(sysRst), .sclIn(sclLine), .sdaIn(sdaWire),
        .sdaOut_q(sdaOut_q), .sdaOe_q(sdaOe_q), .cfgSlaveAddr(cfgSlaveAddr),
        .cfgChargeEnable(cfgChargeEnable), .cfgChargeActiveLow(cfgChargeActiveLow),
        .usbSuspended(usbSuspended), .dcpDetected(dcpDetected), .chargeDetect_q(chargeDetect_q),
        .txWrValid(txWrValid), .txWrData(txWrData), .txWrReady(txWrReady),
        .upValid_q(upValid_q), .upData_q(upData_q), .upReady(upReady),
        .rxLevel(rxLevel), .txLevel(txLevel));
    i2cbr_master u_i2cbr_master (.clk(coreClk), .scl(sclLine), .sdaLow(sdaLow), .sda(sdaWire));

    // 200 MHz core clock
    initial begin
        coreClk = 1'b0;
        forever #2.5 coreClk = ~coreClk;
    end
    // hang guard
    always @(posedge coreClk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic tick();
        @(posedge coreClk);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // write one byte and judge the acknowledge slot (1 means refused)
    task automatic sendByte(input logic [7:0] d, input logic expNak, input string what);
        logic [7:0] r;
        logic       a;
        u_i2cbr_master.xfer(d, 1'b1, r, a);
        check(what, {7'h00, a}, {7'h00, expNak});
    endtask
    task automatic getByte(input logic [7:0] e, input logic nak);
        logic [7:0] r;
        logic       a;
        u_i2cbr_master.xfer(8'hFF, nak, r, a);
        check("read byte", r, e);
    endtask
    // accept upstream bytes and compare with what was written, in order
    task automatic drain(input int limit);
        int g;
        upReady = 1'b1;
        while (expQ.size() > 0) begin
            g = 0;
            while (upValid_q !== 1'b1 && g < limit) begin
                tick();
                g++;
            end
            check("upstream valid", {7'h00, upValid_q}, 8'h01);
            check("upstream byte", upData_q, expQ.pop_front());
            tick();
        end
        upReady = 1'b0;
    endtask

    // four bytes fill the buffer; forwarding starts before the timer could
    task automatic fillWrite();
        check("rx level", {5'h00, rxLevel}, 8'h00);
        u_i2cbr_master.startBit();
        sendByte({7'h5A, 1'b0}, 1'b0, "address ack");
        for (int i = 0; i < 4; i++) begin
            sendByte(PAT[i], 1'b0, "write ack");
            expQ.push_back(PAT[i]);
        end
        u_i2cbr_master.stopBit();
        check("full flush", {7'h00, upValid_q}, 8'h01);
        drain(20);
    endtask
    // one byte waits for the latency timer
    task automatic latencyFlush();
        u_i2cbr_master.startBit();
        sendByte({7'h5A, 1'b0}, 1'b0, "address ack");
        sendByte(8'hC7, 1'b0, "write ack");
        u_i2cbr_master.stopBit();
        check("early flush", {7'h00, upValid_q}, 8'h00);
        expQ.push_back(8'hC7);
        drain(LAT + 50);
    endtask
    // address follows the configured value
    task automatic ownAddress();
        cfgSlaveAddr = 7'h21;
        u_i2cbr_master.startBit();
        sendByte({7'h5A, 1'b0}, 1'b1, "foreign address");
        u_i2cbr_master.stopBit();
        u_i2cbr_master.startBit();
        sendByte({7'h21, 1'b0}, 1'b0, "own address");
        sendByte(8'h99, 1'b0, "write ack");
        u_i2cbr_master.stopBit();
        expQ.push_back(8'h99);
        drain(LAT + 50);
    endtask
    // read with nothing to send, and an unknown general-call command
    task automatic emptyRead();
        u_i2cbr_master.startBit();
        sendByte({7'h21, 1'b1}, 1'b1, "empty read");
        u_i2cbr_master.stopBit();
        u_i2cbr_master.startBit();
        sendByte(8'h00, 1'b0, "general call");
        sendByte(8'h55, 1'b1, "unknown command");
        u_i2cbr_master.stopBit();
    endtask
    // host fills the transmit buffer; count query then burst read via repeated start
    task automatic countRead();
        for (int i = 0; i < 4; i++) begin
            txWrValid = 1'b1;
            txWrData = 8'h10 + i[7:0];
            tick();
        end
        txWrValid = 1'b0;
        tick();
        check("tx ready", {7'h00, txWrReady}, 8'h00);
        check("tx level", {5'h00, txLevel}, 8'h04);
        u_i2cbr_master.startBit();
        sendByte(8'h00, 1'b0, "general call");
        sendByte(8'h0C, 1'b0, "count command");
        u_i2cbr_master.startBit();
        sendByte({7'h21, 1'b1}, 1'b0, "read address");
        getByte(8'h04, 1'b0);
        for (int i = 0; i < 4; i++) begin
            getByte(8'h10 + i[7:0], i == 3);
        end
        u_i2cbr_master.stopBit();
        check("data released", {7'h00, sdaOe_q}, 8'h00);
        check("tx level", {5'h00, txLevel}, 8'h00);
    endtask
    // every combination of charger inputs and polarity
    task automatic chargeOut();
        logic e;
        for (int i = 0; i < 16; i++) begin
            cfgChargeEnable = i[3];
            usbSuspended = i[2];
            dcpDetected = i[1];
            cfgChargeActiveLow = i[0];
            e = (i[3] & i[2] & i[1]) ^ i[0];
            tick();
            tick();
            check("charge detect", {7'h00, chargeDetect_q}, {7'h00, e});
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial begin
        err_count = 0;
        tests_run = 0;
        sysRst = 1'b1;
        cfgSlaveAddr = 7'h5A;
        {cfgChargeEnable, cfgChargeActiveLow, usbSuspended, dcpDetected} = 4'h0;
        txWrValid = 1'b0;
        txWrData = 8'h00;
        upReady = 1'b0;
        repeat (12) tick();
        sysRst = 1'b0;
        repeat (3) tick();
        fillWrite();
        latencyFlush();
        ownAddress();
        emptyRead();
        countRead();
        chargeOut();
        finish_test();
    end
endmodule // i2cbr_bridge_bench

bind i2cbr_bridge i2cbr_chk #(.RX_DEPTH(RX_DEPTH), .RX_AW(RX_AW), .TX_DEPTH(TX_DEPTH),
    .TX_AW(TX_AW)) u_i2cbr_chk (.core_clk, .sys_rst, .sclIn, .sdaIn, .sdaOut_q, .sdaOe_q,
    .cfgChargeEnable, .cfgChargeActiveLow, .usbSuspended, .dcpDetected, .chargeDetect_q,
    .txWrValid, .txWrReady, .upValid_q, .upData_q, .upReady, .rxLevel, .txLevel);
